// [hw/ilm_defs.svh]
// Purpose: constants for the io line drive and function control slice
// Assumes: 32-bit APB data, one aligned word per register
// Notes: offsets are byte addresses
//
// Behaviour
// - open-drain disable strobe clears open-drain
// - open-drain off drives high and low
// - open-drain on drives low only
// - pull-up disable strobe turns pull-up off
// - pull-up enable strobe turns pull-up on
// - pull-up status reads 0 when on
// - pull-up status reads 1 when off
// - function A strobe selects function A
// - function B strobe selects function B
// - function status 0 means function A
// - function status 1 means function B
// - direct-write enable strobe unmasks output writes
// - direct-write disable strobe masks output writes
// - masked line keeps output data on write
// - unmasked line takes output data on write
`ifndef ILM_DEFS_SVH
`define ILM_DEFS_SVH

`define ILM_OFS_OD_ENABLE      12'h000
`define ILM_OFS_OD_DISABLE     12'h004
`define ILM_OFS_OD_STATE       12'h008
`define ILM_OFS_PU_DISABLE     12'h00C
`define ILM_OFS_PU_ENABLE      12'h010
`define ILM_OFS_PU_OFF_STATE   12'h014
`define ILM_OFS_FN_A_SELECT    12'h018
`define ILM_OFS_FN_B_SELECT    12'h01C
`define ILM_OFS_FN_STATE       12'h020
`define ILM_OFS_DW_ENABLE      12'h024
`define ILM_OFS_DW_DISABLE     12'h028
`define ILM_OFS_DW_STATE       12'h02C
`define ILM_OFS_OUT_DATA       12'h030

`define ILM_RST_OD             32'h00000000
`define ILM_RST_PU_ON          32'hFFFFFFFF
`define ILM_RST_FN_B           32'h00000000
`define ILM_RST_DW             32'h00000000
`define ILM_RST_OUT_DATA       32'h00000000

`endif

// [hw/ilm_pkg.sv]
// Purpose: types for the io line drive and function control slice
// Assumes: nothing beyond the defines header
// Notes: line count fixed at 32
package ilm_pkg;
   typedef logic [31:0] ilm_word_t;

   typedef struct packed {
      ilm_word_t openDrain;
      ilm_word_t pullUpOn;
      ilm_word_t functionB;
      ilm_word_t directWriteMask;
      ilm_word_t outData;
   } ilm_line_cfg_s;

   typedef struct packed {
      ilm_word_t padOut;
      ilm_word_t padOutEnN;
      ilm_word_t pullUpEn;
      ilm_word_t functionB;
   } ilm_pad_ctl_s;
endpackage

// [hw/ilm_line_ctrl.sv]
// Purpose: per-line open-drain, pull-up, function select and direct-write mask
// Assumes: APB slave, zero wait states, clk 10 MHz, srst synchronous
// Notes: pads get value plus active-low output enable per line
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ilm_defs.svh"

module ilm_line_ctrl
   import ilm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        clkEn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output ilm_pad_ctl_s     padCtl
);

   // ----------------------------------------
   // storage and next values
   // ----------------------------------------
   ilm_line_cfg_s cfg;
   ilm_line_cfg_s next_cfg;
   ilm_pad_ctl_s  next_padCtl;
   logic [31:0]   next_prdata;
   logic          next_pslverr;
   logic          next_pready;

   // ----------------------------------------
   // bus phases
   // ----------------------------------------
   logic          setupPh;
   logic          accessPh;
   logic          wrAcc;
   logic          rdAcc;

   // pready is registered from setup, so it is high in the access cycle
   assign setupPh  = psel && !penable;
   assign accessPh = psel && penable && pready;

   // writes land at the edge that completes the access, not at setup
   assign wrAcc = accessPh && pwrite;

   // read data is fetched at setup so that it stands through the access cycle
   assign rdAcc = setupPh && !pwrite;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   logic          hitOdEnable;
   logic          hitOdDisable;
   logic          hitOdState;
   logic          hitPuDisable;
   logic          hitPuEnable;
   logic          hitPuOffState;
   logic          hitFnASelect;
   logic          hitFnBSelect;
   logic          hitFnState;
   logic          hitDwEnable;
   logic          hitDwDisable;
   logic          hitDwState;
   logic          hitOutData;
   logic          known;

   assign hitOdEnable   = (paddr == `ILM_OFS_OD_ENABLE);
   assign hitOdDisable  = (paddr == `ILM_OFS_OD_DISABLE);
   assign hitOdState    = (paddr == `ILM_OFS_OD_STATE);
   assign hitPuDisable  = (paddr == `ILM_OFS_PU_DISABLE);
   assign hitPuEnable   = (paddr == `ILM_OFS_PU_ENABLE);
   assign hitPuOffState = (paddr == `ILM_OFS_PU_OFF_STATE);
   assign hitFnASelect  = (paddr == `ILM_OFS_FN_A_SELECT);
   assign hitFnBSelect  = (paddr == `ILM_OFS_FN_B_SELECT);
   assign hitFnState    = (paddr == `ILM_OFS_FN_STATE);
   assign hitDwEnable   = (paddr == `ILM_OFS_DW_ENABLE);
   assign hitDwDisable  = (paddr == `ILM_OFS_DW_DISABLE);
   assign hitDwState    = (paddr == `ILM_OFS_DW_STATE);
   assign hitOutData    = (paddr == `ILM_OFS_OUT_DATA);

   // strobes, status words and out data are all mapped; anything else is an error
   assign known = hitOdEnable
                | hitOdDisable
                | hitOdState
                | hitPuDisable
                | hitPuEnable
                | hitPuOffState
                | hitFnASelect
                | hitFnBSelect
                | hitFnState
                | hitDwEnable
                | hitDwDisable
                | hitDwState
                | hitOutData;

   // ----------------------------------------
   // read data
   // ----------------------------------------
   // strobes and unmapped words read 0; outside a read the word is held
   always_comb begin
      next_prdata = prdata;
      if (rdAcc) begin
         next_prdata = 32'h00000000;
         if (hitOdState) begin
            next_prdata = cfg.openDrain;
         end
         if (hitPuOffState) begin
            next_prdata = ~cfg.pullUpOn;
         end
         if (hitFnState) begin
            next_prdata = cfg.functionB;
         end
         if (hitDwState) begin
            next_prdata = cfg.directWriteMask;
         end
         if (hitOutData) begin
            next_prdata = cfg.outData;
         end
      end
   end

   // ----------------------------------------
   // handshake and error
   // ----------------------------------------
   // zero wait: every setup is answered in the very next cycle
   always_comb begin
      next_pready  = setupPh;
      next_pslverr = pslverr;
      if (setupPh) begin
         next_pslverr = !known;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
         pready  <= 1'b0;
      end else if (clkEn) begin
         prdata  <= next_prdata;
         pslverr <= next_pslverr;
         pready  <= next_pready;
      end
   end

   // ----------------------------------------
   // per-line setting bits
   // ----------------------------------------
   // bit n of every word belongs to line n, so the logic repeats per line
   for (genvar n = 0; n < 32; n++) begin : g_line
      // a written 0 leaves the bit alone, a written 1 sets or clears it
      always_comb begin
         next_cfg.openDrain[n]       = cfg.openDrain[n];
         next_cfg.pullUpOn[n]        = cfg.pullUpOn[n];
         next_cfg.functionB[n]       = cfg.functionB[n];
         next_cfg.directWriteMask[n] = cfg.directWriteMask[n];
         next_cfg.outData[n]         = cfg.outData[n];
         if (wrAcc && pwdata[n]) begin
            if (hitOdEnable) begin
               next_cfg.openDrain[n] = 1'b1;
            end
            if (hitOdDisable) begin
               next_cfg.openDrain[n] = 1'b0;
            end
            if (hitPuDisable) begin
               next_cfg.pullUpOn[n] = 1'b0;
            end
            if (hitPuEnable) begin
               next_cfg.pullUpOn[n] = 1'b1;
            end
            if (hitFnASelect) begin
               next_cfg.functionB[n] = 1'b0;
            end
            if (hitFnBSelect) begin
               next_cfg.functionB[n] = 1'b1;
            end
            if (hitDwEnable) begin
               next_cfg.directWriteMask[n] = 1'b1;
            end
            if (hitDwDisable) begin
               next_cfg.directWriteMask[n] = 1'b0;
            end
         end
         // masked lines keep their value, unmasked ones take the new bit
         if (wrAcc && hitOutData && cfg.directWriteMask[n]) begin
            next_cfg.outData[n] = pwdata[n];
         end
      end

      // ----------------------------------------
      // pad drive for this line
      // ----------------------------------------
      // computed from the next settings so pads move at the same edge as bits
      always_comb begin
         if (next_cfg.openDrain[n]) begin
            // open-drain: pull low for a 0, release for a 1, never drive high
            next_padCtl.padOut[n]    = 1'b0;
            next_padCtl.padOutEnN[n] = next_cfg.outData[n];
         end else begin
            next_padCtl.padOut[n]    = next_cfg.outData[n];
            next_padCtl.padOutEnN[n] = 1'b0;
         end
         next_padCtl.pullUpEn[n]  = next_cfg.pullUpOn[n];
         next_padCtl.functionB[n] = next_cfg.functionB[n];
      end
   end

   // ----------------------------------------
   // setting registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         cfg.openDrain       <= `ILM_RST_OD;
         cfg.pullUpOn        <= `ILM_RST_PU_ON;
         cfg.functionB       <= `ILM_RST_FN_B;
         cfg.directWriteMask <= `ILM_RST_DW;
         cfg.outData         <= `ILM_RST_OUT_DATA;
      end else if (clkEn) begin
         cfg <= next_cfg;
      end
   end

   // ----------------------------------------
   // pad registers
   // ----------------------------------------
   // reset drives every line low in push-pull, matching out data 0
   always_ff @(posedge clk) begin
      if (srst) begin
         padCtl.padOut    <= 32'h00000000;
         padCtl.padOutEnN <= 32'h00000000;
         padCtl.pullUpEn  <= `ILM_RST_PU_ON;
         padCtl.functionB <= `ILM_RST_FN_B;
      end else if (clkEn) begin
         padCtl <= next_padCtl;
      end
   end

   // ----------------------------------------
   // limitations
   // ----------------------------------------
   // no byte strobes: every write covers all 32 lines at once
   // strobes read back 0; settings are seen only through status words and out data
   // an unmapped write is dropped and flagged like an unmapped read
   // with clkEn low the bus is stalled as well, pready included

endmodule
`default_nettype wire

// [verif/ilm_line_ctrl_asserts.sv]
// Purpose: port checks for ilm_line_ctrl
// Assumes: zero-wait APB, pad struct registered
// Notes: bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module ilm_line_ctrl_asserts
   import ilm_pkg::*;
(
   input wire logic         clk,
   input wire logic         srst,
   input wire logic         clkEn,
   input wire logic         psel,
   input wire logic         penable,
   input wire logic         pwrite,
   input wire logic [11:0]  paddr,
   input wire logic [31:0]  pwdata,
   input wire logic [31:0]  prdata,
   input wire logic         pready,
   input wire logic         pslverr,
   input wire ilm_pad_ctl_s padCtl
);
   // ----------------------------
   // setup-edge, write-edge and pad relations
   // ----------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   wire logic      su = psel && !penable && clkEn;
   wire logic      ws = psel && penable && pready && pwrite && clkEn;
   wire ilm_word_t pu = padCtl.pullUpEn;
   wire ilm_word_t fb = padCtl.functionB;
   property p_rdy; su |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready late");
   property p_pue; ws && paddr == 12'h010 |=> pu == ($past(pu) | $past(pwdata)); endproperty
   a_pue: assert property (p_pue) else $error("pull-up set");
   property p_pud; ws && paddr == 12'h00C |=> pu == ($past(pu) & ~$past(pwdata)); endproperty
   a_pud: assert property (p_pud) else $error("pull-up clear");
   property p_fa; ws && paddr == 12'h018 |=> fb == ($past(fb) & ~$past(pwdata)); endproperty
   a_fa: assert property (p_fa) else $error("func A");
   property p_fb; ws && paddr == 12'h01C |=> fb == ($past(fb) | $past(pwdata)); endproperty
   a_fb: assert property (p_fb) else $error("func B");
   property p_odd; ws && paddr == 12'h004 |=> (padCtl.padOutEnN & $past(pwdata)) == 32'h0; endproperty
   a_odd: assert property (p_odd) else $error("drive off");
   property p_od; (padCtl.padOut & padCtl.padOutEnN) == 32'h0; endproperty
   a_od: assert property (p_od) else $error("high driven");
   property p_pus; su && !pwrite && paddr == 12'h014 |=> prdata == ~pu; endproperty
   a_pus: assert property (p_pus) else $error("pull status");
   property p_err; su && paddr > 12'h030 |=> pslverr; endproperty
   a_err: assert property (p_err) else $error("no error");
endmodule
`default_nettype wire

// [verif/ilm_line_ctrl_tb_top.sv]
// Purpose: directed bench for ilm_line_ctrl
// Assumes: zero-wait APB slave, clkEn high
// Notes: one task per scenario
`timescale 1ns/1ps
`default_nettype none
module ilm_line_ctrl_tb_top
   import ilm_pkg::*;
   ;
   logic         clk = 0, srst = 1, clkEn = 1, psel = 0, penable = 0, pwrite = 0, er;
   logic [11:0]  paddr = 12'h0;
   logic [31:0]  pwdata = 32'h0, prdata, rd;
   logic         pready, pslverr;
   ilm_pad_ctl_s padCtl;
   int           err_count = 0, check_count = 0;
   ilm_line_ctrl dut (.clk(clk), .srst(srst), .clkEn(clkEn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .padCtl(padCtl));
   // ----------------------------
   // bus and compare tasks
   // ----------------------------
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1 && n++ < 20);
      if (pready !== 1'h1) err_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ----------------------------
   // scenarios
   // ----------------------------
   task automatic t_pull();
      rc(12'h014, 32'h0);
      apb(1'h1, 12'h00C, 32'hA5A5A5A5);
      rc(12'h014, 32'hA5A5A5A5);
      apb(1'h1, 12'h010, 32'h0000FFFF);
      rc(12'h014, 32'hA5A50000);
      chk(padCtl.pullUpEn, 32'h5A5AFFFF);
   endtask
   task automatic t_func();
      apb(1'h1, 12'h01C, 32'hF0F0F0F0);
      rc(12'h020, 32'hF0F0F0F0);
      apb(1'h1, 12'h018, 32'h30000001);
      rc(12'h020, 32'hC0F0F0F0);
      chk(padCtl.functionB, 32'hC0F0F0F0);
   endtask
   task automatic t_out();
      apb(1'h1, 12'h030, 32'hFFFFFFFF);
      rc(12'h030, 32'h0);
      apb(1'h1, 12'h024, 32'h000000FF);
      apb(1'h1, 12'h030, 32'hFFFFFFFF);
      rc(12'h030, 32'h000000FF);
      apb(1'h1, 12'h028, 32'h0000000F);
      apb(1'h1, 12'h030, 32'h0);
      rc(12'h030, 32'h0000000F);
      rc(12'h02C, 32'h000000F0);
      chk(padCtl.padOut, 32'h0000000F);
      apb(1'h1, 12'h000, 32'h00000003);
      chk(padCtl.padOutEnN, 32'h00000003);
      chk(padCtl.padOut, 32'h0000000C);
      apb(1'h1, 12'h004, 32'h00000001);
      rc(12'h008, 32'h00000002);
      chk(padCtl.padOutEnN, 32'h00000002);
   endtask
   task automatic t_err();
      rc(12'h0FC, 32'h0);
      chk(32'(er), 32'h1);
   endtask
   initial forever #50 clk = ~clk;
   initial begin
      #200000;
      err_count++;
      final_report();
   end
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'h0;
      @(posedge clk);
      t_pull();
      t_func();
      t_out();
      t_err();
      final_report();
   end
endmodule
bind ilm_line_ctrl ilm_line_ctrl_asserts u_chk (.clk(clk), .srst(srst), .clkEn(clkEn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .padCtl(padCtl));
`default_nettype wire
